// *** design/ebc_phase_seq.sv ***
// external bus cycle phase sequencer with wishbone timing registers
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module ebc_phase_seq
  import ebc_phase_pkg::*;
(
  // clock and reset
  input  wire logic            CLK_I,
  input  wire logic            RST_N_I,
  // wishbone slave
  input  wire logic            CYC_I,
  input  wire logic            STB_I,
  input  wire logic            WE_I,
  input  wire logic [7:0]      ADR_I,
  input  wire logic [3:0]      SEL_I,
  input  wire logic [31:0]     DAT_I,
  output logic      [31:0]     DAT_O,
  output logic                 ACK_O,
  // bus cycle request
  input  wire logic            REQ_I,
  input  wire logic [CS_W-1:0] CS_SEL_I,
  input  wire logic            WINDOW_CHANGE_I,
  // phase outputs
  output logic                 BUSY_O,
  output logic                 DONE_O,
  output logic [2:0]           PHASE_O,
  output logic                 ADDR_SETUP_O,
  output logic                 CMD_DELAY_O,
  output logic                 DATA_SETUP_O,
  output logic                 ACCESS_O,
  output logic                 HOLD_O
);

  logic [CFG_W-1:0] cfg [NUM_CS];
  logic [CFG_W-1:0] next_cfg [NUM_CS];
  logic [CFG_W-1:0] act_cfg;
  logic [CFG_W-1:0] next_act_cfg;
  logic             busy;
  logic             next_busy;
  logic [4:0]       strobe;
  logic [4:0]       next_strobe;
  phase_e           phase;
  phase_e           next_phase;
  logic [4:0]       cnt;
  logic [4:0]       next_cnt;
  logic             done;
  logic             next_done;
  logic             ack;
  logic             next_ack;
  logic [31:0]      rdat;
  logic [31:0]      next_rdat;

  // address setup base, one or two clocks
  function automatic logic [2:0] setup_base(input logic [CFG_W-1:0] c);
    setup_base = {2'b00, c[AB_POS]} + 3'd1;
  endfunction

  // extra setup clocks spent only when the address window changes
  function automatic logic [1:0] window_ext(input logic [CFG_W-1:0] c);
    window_ext = c[EXT_POS +: 2];
  endfunction

  // command delay in clocks
  function automatic logic [5:0] cmd_len(input logic [CFG_W-1:0] c);
    cmd_len = {4'd0, c[CMD_POS +: 2]};
  endfunction

  // write data setup or tristate turnaround in clocks
  function automatic logic [5:0] data_len(input logic [CFG_W-1:0] c);
    data_len = {5'd0, c[DS_POS]};
  endfunction

  // access in clocks; the field holds length minus one so 32 fits in five bits
  function automatic logic [5:0] access_len(input logic [CFG_W-1:0] c);
    access_len = {1'b0, c[ACC_POS +: 5]} + 6'd1;
  endfunction

  // address and write data hold in clocks
  function automatic logic [5:0] hold_len(input logic [CFG_W-1:0] c);
    hold_len = {4'd0, c[HOLD_POS +: 2]};
  endfunction

  // total setup clocks, five at most
  function automatic logic [4:0] setup_len(input logic [CFG_W-1:0] c, input logic ext);
    logic [2:0] n;
    n = setup_base(c);
    if (ext) begin
      n = n + {1'b0, window_ext(c)};
    end
    setup_len = {2'b00, n};
  endfunction

  // length of a phase in clocks, zero means skip
  function automatic logic [5:0] phase_len(input phase_e p, input logic [CFG_W-1:0] c);
    phase_len = 6'd0;
    unique case (p)
      PH_CMD:  phase_len = cmd_len(c);
      PH_DATA: phase_len = data_len(c);
      PH_ACC:  phase_len = access_len(c);
      PH_HOLD: phase_len = hold_len(c);
      default: phase_len = 6'd0;
    endcase
  endfunction

  // next phase after p that has nonzero length, or idle
  function automatic phase_e after(input phase_e p, input logic [CFG_W-1:0] c);
    after = PH_IDLE;
    unique case (p)
      PH_SETUP: after = (phase_len(PH_CMD, c) != 6'd0) ? PH_CMD :
                        (phase_len(PH_DATA, c) != 6'd0) ? PH_DATA : PH_ACC;
      PH_CMD:   after = (phase_len(PH_DATA, c) != 6'd0) ? PH_DATA : PH_ACC;
      PH_DATA:  after = PH_ACC;
      PH_ACC:   after = (phase_len(PH_HOLD, c) != 6'd0) ? PH_HOLD : PH_IDLE;
      default:  after = PH_IDLE;
    endcase
  endfunction

  // count to load on entering phase p: its length minus one, or 0 for idle
  function automatic logic [4:0] first_cnt(input phase_e p, input logic [CFG_W-1:0] c);
    if (p == PH_IDLE) begin
      first_cnt = 5'd0;
    end else begin
      first_cnt = 5'(phase_len(p, c) - 6'd1);
    end
  endfunction

  // merges a write into a config word lane by lane; lanes above bit 12 do not exist
  function automatic logic [CFG_W-1:0] lane_merge(input logic [CFG_W-1:0] old,
                                                  input logic [31:0]      d,
                                                  input logic [3:0]       sel);
    lane_merge = old;
    if (sel[0]) begin
      lane_merge[7:0] = d[7:0];
    end
    if (sel[1]) begin
      lane_merge[CFG_W-1:8] = d[CFG_W-1:8];
    end
  endfunction

  // register file, writes honour byte lanes
  always_comb begin
    for (int i = 0; i < NUM_CS; i++) begin
      next_cfg[i] = cfg[i];
    end
    next_ack = CYC_I && STB_I && !ack;
    next_rdat = rdat;
    if (CYC_I && STB_I && !ack) begin
      next_rdat = 32'h0000_0000;
      unique case (ADR_I)
        ADDR_TIMING0, ADDR_TIMING1, ADDR_TIMING2, ADDR_TIMING3: begin
          next_rdat = {19'h0, cfg[ADR_I[3:2]]};
          if (WE_I) begin
            next_cfg[ADR_I[3:2]] = lane_merge(cfg[ADR_I[3:2]], DAT_I, SEL_I);
          end
        end
        ADDR_STATUS: begin
          next_rdat = {24'h0, cnt, phase};
        end
        // unmapped: reads give zero, writes are dropped, the access is still acked
        default: begin
          next_rdat = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < NUM_CS; i++) begin
        cfg[i] <= CFG_RESET;
      end
      ack  <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      cfg  <= next_cfg;
      ack  <= next_ack;
      rdat <= next_rdat;
    end
  end

  // phase sequencer; cnt holds clocks left in the current phase after this one
  // a request while busy is simply not looked at
  always_comb begin
    next_phase   = phase;
    next_cnt     = cnt;
    next_act_cfg = act_cfg;
    unique case (phase)
      PH_IDLE: begin
        if (REQ_I) begin
          // config is latched so a rewrite mid cycle cannot bend it
          next_act_cfg = cfg[CS_SEL_I];
          next_phase   = PH_SETUP;
          next_cnt     = setup_len(cfg[CS_SEL_I], WINDOW_CHANGE_I) - 5'd1;
        end
      end
      PH_SETUP: begin
        if (cnt != 5'd0) begin
          next_cnt = cnt - 5'd1;
        end else begin
          next_phase = after(PH_SETUP, act_cfg);
          next_cnt   = first_cnt(next_phase, act_cfg);
        end
      end
      PH_CMD: begin
        if (cnt != 5'd0) begin
          next_cnt = cnt - 5'd1;
        end else begin
          next_phase = after(PH_CMD, act_cfg);
          next_cnt   = first_cnt(next_phase, act_cfg);
        end
      end
      PH_DATA: begin
        if (cnt != 5'd0) begin
          next_cnt = cnt - 5'd1;
        end else begin
          next_phase = after(PH_DATA, act_cfg);
          next_cnt   = first_cnt(next_phase, act_cfg);
        end
      end
      PH_ACC: begin
        if (cnt != 5'd0) begin
          next_cnt = cnt - 5'd1;
        end else begin
          next_phase = after(PH_ACC, act_cfg);
          next_cnt   = first_cnt(next_phase, act_cfg);
        end
      end
      PH_HOLD: begin
        if (cnt != 5'd0) begin
          next_cnt = cnt - 5'd1;
        end else begin
          next_phase = after(PH_HOLD, act_cfg);
          next_cnt   = first_cnt(next_phase, act_cfg);
        end
      end
      default: begin
        // codes 6 and 7 are never entered; recover to idle
        next_phase = PH_IDLE;
        next_cnt   = 5'd0;
      end
    endcase
    // done pulses in the first idle clock after a cycle ends
    next_done = (phase != PH_IDLE) && (next_phase == PH_IDLE);
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      phase    <= PH_IDLE;
      cnt      <= 5'd0;
      act_cfg  <= CFG_RESET;
      done     <= 1'b0;
    end else begin
      phase    <= next_phase;
      cnt      <= next_cnt;
      act_cfg  <= next_act_cfg;
      done     <= next_done;
    end
  end

  // phase strobes are registered from the next phase, so they line up with
  // PHASE_O and never glitch while the phase code changes
  always_comb begin
    next_busy   = (next_phase != PH_IDLE);
    next_strobe = 5'h00;
    unique case (next_phase)
      PH_IDLE:  next_strobe = 5'h00;
      PH_SETUP: next_strobe = 5'h01;
      PH_CMD:   next_strobe = 5'h02;
      PH_DATA:  next_strobe = 5'h04;
      PH_ACC:   next_strobe = 5'h08;
      PH_HOLD:  next_strobe = 5'h10;
      default:  next_strobe = 5'h00;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy   <= 1'b0;
      strobe <= 5'h00;
    end else begin
      busy   <= next_busy;
      strobe <= next_strobe;
    end
  end

  // no ready from the far side: access ends on the count alone
  assign ACK_O        = ack;
  assign DAT_O        = rdat;
  assign BUSY_O       = busy;
  assign DONE_O       = done;
  assign PHASE_O      = phase;
  assign ADDR_SETUP_O = strobe[0];
  assign CMD_DELAY_O  = strobe[1];
  assign DATA_SETUP_O = strobe[2];
  assign ACCESS_O     = strobe[3];
  assign HOLD_O       = strobe[4];

endmodule

// *** design/ebc_phase_pkg.sv ***
// constants for the external bus cycle phase sequencer
package ebc_phase_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] ADDR_TIMING0  = 8'h00;
  localparam logic [7:0] ADDR_TIMING1  = 8'h04;
  localparam logic [7:0] ADDR_TIMING2  = 8'h08;
  localparam logic [7:0] ADDR_TIMING3  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  // chip_select_timing_config field positions
  localparam int AB_POS = 0;   // 1 bit: address setup base 1 or 2
  localparam int EXT_POS = 1;  // 2 bits: window change extension 0..3
  localparam int CMD_POS = 3;  // 2 bits: command delay 0..3
  localparam int DS_POS = 5;   // 1 bit: data setup / tristate 0..1
  localparam int ACC_POS = 6;  // 5 bits: access length minus one
  localparam int HOLD_POS = 11; // 2 bits: hold 0..3
  localparam int CFG_W = 13;
  localparam logic [CFG_W-1:0] CFG_RESET = 13'h0000;
  localparam int NUM_CS = 4;
  localparam int CS_W = 2;
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_SETUP = 3'b001,
    PH_CMD   = 3'b010,
    PH_DATA  = 3'b011,
    PH_ACC   = 3'b100,
    PH_HOLD  = 3'b101
  } phase_e;
endpackage

// *** bench/ebc_phase_seq_assertions.sv ***
// port assertions for the phase sequencer
`timescale 1ns/1ps
module ebc_phase_seq_assertions (
  input wire logic       CLK_I,
  input wire logic       RST_N_I,
  input wire logic       REQ_I,
  input wire logic       BUSY_O,
  input wire logic       DONE_O,
  input wire logic [2:0] PHASE_O,
  input wire logic       ADDR_SETUP_O,
  input wire logic       CMD_DELAY_O,
  input wire logic       DATA_SETUP_O,
  input wire logic       ACCESS_O,
  input wire logic       HOLD_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence start_s; !BUSY_O && REQ_I; endsequence
  sequence end_s; $fell(BUSY_O); endsequence
  start_setup_a: assert property (start_s |=> ADDR_SETUP_O)
    else $error("no setup after request");
  phase_order_a: assert property ($past(BUSY_O) && $changed(PHASE_O)
    |-> PHASE_O > $past(PHASE_O) || PHASE_O == 3'h0) else $error("phase order");
  setup_max_a: assert property (ADDR_SETUP_O [*5] |=> !ADDR_SETUP_O)
    else $error("setup too long");
  cmd_max_a: assert property (CMD_DELAY_O [*3] |=> !CMD_DELAY_O)
    else $error("command delay too long");
  access_max_a: assert property ($rose(ACCESS_O) |-> ##[1:32] !ACCESS_O)
    else $error("access too long");
  data_max_a: assert property (DATA_SETUP_O |=> !DATA_SETUP_O)
    else $error("data setup too long");
  hold_max_a: assert property (HOLD_O [*3] |=> !HOLD_O)
    else $error("hold too long");
  cycle_end_a: assert property (end_s |-> DONE_O && $past(PHASE_O) inside {3'h4, 3'h5})
    else $error("bad cycle end");
endmodule
bind ebc_phase_seq ebc_phase_seq_assertions chk (.CLK_I, .RST_N_I, .REQ_I, .BUSY_O, .DONE_O,
  .PHASE_O, .ADDR_SETUP_O, .CMD_DELAY_O, .DATA_SETUP_O, .ACCESS_O, .HOLD_O);

// *** bench/ext_dev_model.sv ***
// behavioural external device that counts its access cycles
`timescale 1ns/1ps
module ext_dev_model (
  input  wire logic clk_i,
  input  wire logic access_i,
  output int        acc_cnt_o
);
  bit run;
  // no handshake back: the device must finish inside the access phase
  always @(posedge clk_i) begin
    if (access_i) acc_cnt_o <= run ? acc_cnt_o + 1 : 1;
    run <= access_i;
  end
endmodule

// *** bench/tb_ebc_phase_seq.sv ***
// testbench for the bus cycle phase sequencer
`timescale 1ns/1ps
module tb_ebc_phase_seq;
  import ebc_phase_pkg::*;
  logic clk, rst_n, cyc, stb, we, req, win, ack, busy, done, s1, s2, s3, s4, s5;
  logic [7:0] adr;
  logic [1:0] cs;
  logic [2:0] phase;
  logic [31:0] dat, dato, q;
  int failures, num_checks, acc_cnt;
  ebc_phase_seq uut (.CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dato), .ACK_O(ack), .REQ_I(req),
    .CS_SEL_I(cs), .WINDOW_CHANGE_I(win), .BUSY_O(busy), .DONE_O(done), .PHASE_O(phase),
    .ADDR_SETUP_O(s1), .CMD_DELAY_O(s2), .DATA_SETUP_O(s3), .ACCESS_O(s4), .HOLD_O(s5));
  ext_dev_model dev (.clk_i(clk), .access_i(s4), .acc_cnt_o(acc_cnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 20);
    if (i >= 20) begin failures++; summarize(); end
    q = dato;
    {cyc, stb} <= 2'b00;
  endtask
  task bus_cycle(input logic [1:0] c, input logic w, input int e[5]);
    int n[6];
    int i;
    n = '{default: 0};
    i = 0;
    @(posedge clk);
    {req, cs, win} <= {1'b1, c, w};
    @(posedge clk);
    req <= 1'b0;
    do begin @(posedge clk); n[phase]++; i++; end while (done !== 1'b1 && i < 200);
    if (i >= 200) begin failures++; summarize(); end
    for (i = 0; i < 5; i++) check(n[i + 1], e[i]);
    check(acc_cnt, e[3]);
    $display("bus cycle on select %0d done", c);
  endtask
  task test_regs;
    check(phase, 3'h0);
    wb(1'b0, ADDR_TIMING0, 32'h0); check(q, CFG_RESET);
    wb(1'b0, ADDR_STATUS, 32'h0); check(q, 32'h0);
    // all fields at their maximum on select 1, a mixed setting on select 3
    wb(1'b1, ADDR_TIMING1, 32'h1FFF); wb(1'b1, ADDR_TIMING3, 32'h10CA);
    wb(1'b1, 8'h20, 32'hFFFF); wb(1'b0, 8'h20, 32'h0); check(q, 32'h0);
    wb(1'b0, ADDR_TIMING1, 32'h0); check(q, 32'h1FFF);
    $display("register test done");
  endtask
  initial begin
    {rst_n, cyc, stb, we, req, win, adr, cs, dat} = '0;
    failures = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    bus_cycle(2'h1, 1'b1, '{5, 3, 1, 32, 3});
    bus_cycle(2'h1, 1'b0, '{2, 3, 1, 32, 3});
    bus_cycle(2'h2, 1'b1, '{1, 0, 0, 1, 0});
    bus_cycle(2'h3, 1'b1, '{2, 1, 0, 4, 2});
    summarize();
  end
endmodule
